// ### hw/sac_pkg.sv
package sac_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_NS = 4;
  localparam int CS_FILT_NS = 1000;
  localparam int CS_FILT_CYC = (CS_FILT_NS + CLK_NS - 1) / CLK_NS;
  localparam int CONV_NS = 8000;
  localparam int CONV_CYC = (CONV_NS + CLK_NS - 1) / CLK_NS;
  localparam int CONV_MAX_NS = 10000;
  localparam int CONV_MAX_CYC = CONV_MAX_NS / CLK_NS;
  localparam int EOC_FALL_NS = 2200;
  localparam int EOC_FALL_CYC = EOC_FALL_NS / CLK_NS;
  localparam int DOUT_EOC_NS = 100;
  localparam int DOUT_EOC_CYC = DOUT_EOC_NS / CLK_NS;
  localparam int OE_OFF_NS = 150;
  localparam int OE_OFF_CYC = OE_OFF_NS / CLK_NS;
  localparam int OE_ON_NS = 1300;
  localparam int OE_ON_CYC = OE_ON_NS / CLK_NS;
  // ==========================================================
  // Command word layout
  localparam logic [3:0] CMD_BITS = 4'h8;
  localparam logic [4:0] ACQ_START = 5'h04;
  localparam int ADDR_POS = 4;
  localparam int LEN_POS = 2;
  localparam int LSBF_POS = 1;
  localparam int BIP_POS = 0;
  localparam logic [1:0] LEN_8 = 2'h1;
  localparam logic [1:0] LEN_16 = 2'h3;
  localparam logic [4:0] NCLK_8 = 5'h08;
  localparam logic [4:0] NCLK_12 = 5'h0c;
  localparam logic [4:0] NCLK_16 = 5'h10;
  // ==========================================================
  // Self-test and clamp codes
  localparam logic [3:0] ST_MID = 4'hb;
  localparam logic [3:0] ST_ZERO = 4'hc;
  localparam logic [3:0] ST_FULL = 4'hd;
  localparam logic [11:0] CODE_MID = 12'h800;
  localparam logic [11:0] CODE_ZERO = 12'h000;
  localparam logic [11:0] CODE_FULL = 12'hfff;
  // ==========================================================
  // Reset values
  localparam logic [15:0] RES_RST = 16'h0000;
  localparam logic [7:0] CMD_RST = 8'h00;
  typedef enum logic [1:0] {SAC_IDLE, SAC_CONV, SAC_PUSH} sac_state_t;
endpackage

// ### hw/sac_buf2.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Two-entry result buffer
module sac_buf2 #(
  parameter int W = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem_ff [2];
  logic [W-1:0] nxt_mem [2];
  logic wr_ff, rd_ff, nxt_wr, nxt_rd;
  logic [1:0] cnt_ff, nxt_cnt;
  logic push, pop;

  assign in_ready = (cnt_ff != 2'h2);
  assign out_valid = (cnt_ff != 2'h0);
  assign out_data = mem_ff[rd_ff];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb
  begin
    nxt_mem = mem_ff;
    nxt_wr = wr_ff;
    nxt_rd = rd_ff;
    nxt_cnt = cnt_ff;
    if (push)
    begin
      nxt_mem[wr_ff] = in_data;
      nxt_wr = ~wr_ff;
    end
    if (pop)
      nxt_rd = ~rd_ff;
    if (push && !pop)
      nxt_cnt = cnt_ff + 2'h1;
    else if (pop && !push)
      nxt_cnt = cnt_ff - 2'h1;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      mem_ff[0] <= '0;
      mem_ff[1] <= '0;
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      cnt_ff <= 2'h0;
    end
    else
    begin
      mem_ff <= nxt_mem;
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end
endmodule
`default_nettype wire

// ### hw/sac_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module sac_ctrl (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cs_n_pin,
  input wire logic io_clk_pin,
  input wire logic din_pin,
  input wire logic [11:0] ana_code,
  input wire logic ana_over,
  input wire logic ana_under,
  output logic eoc,
  output logic dout,
  output logic dout_oe_n,
  output logic [3:0] mux_sel,
  output logic sample
);
  localparam int EOC_W = sac_pkg::EOC_FALL_CYC;
  localparam int CONV_W = sac_pkg::CONV_MAX_CYC;
  localparam int DOUT_W = sac_pkg::DOUT_EOC_CYC;
  localparam int OFF_W = sac_pkg::OE_OFF_CYC;

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // ==========================================================
  // Pin synchronisers
  logic cs_s1_ff, cs_s2_ff, io_s1_ff, io_s2_ff, io_s3_ff;
  logic din_s1_ff, din_s2_ff;
  logic io_rise, io_fall;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cs_s1_ff <= 1'b1;
      cs_s2_ff <= 1'b1;
      io_s1_ff <= 1'b0;
      io_s2_ff <= 1'b0;
      io_s3_ff <= 1'b0;
      din_s1_ff <= 1'b0;
      din_s2_ff <= 1'b0;
    end
    else
    begin
      cs_s1_ff <= cs_n_pin;
      cs_s2_ff <= cs_s1_ff;
      io_s1_ff <= io_clk_pin;
      io_s2_ff <= io_s1_ff;
      io_s3_ff <= io_s2_ff;
      din_s1_ff <= din_pin;
      din_s2_ff <= din_s1_ff;
    end
  end

  assign io_rise = io_s2_ff & ~io_s3_ff;
  assign io_fall = ~io_s2_ff & io_s3_ff;

  // ==========================================================
  // Select glitch filter
  logic cs_act_ff, nxt_cs_act;
  logic [7:0] filt_cnt_ff, nxt_filt_cnt;
  logic cs_sel_p, cs_desel_p;

  always_comb
  begin
    nxt_cs_act = cs_act_ff;
    nxt_filt_cnt = 8'h00;
    cs_sel_p = 1'b0;
    cs_desel_p = 1'b0;
    // Mismatch: pin level differs from the accepted one
    if (cs_s2_ff == cs_act_ff)
    begin
      if (filt_cnt_ff == 8'(sac_pkg::CS_FILT_CYC - 1))
      begin
        nxt_cs_act = ~cs_act_ff;
        cs_sel_p = ~cs_act_ff;
        cs_desel_p = cs_act_ff;
      end
      else
        nxt_filt_cnt = filt_cnt_ff + 8'h01;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cs_act_ff <= 1'b0;
      filt_cnt_ff <= 8'h00;
    end
    else
    begin
      cs_act_ff <= nxt_cs_act;
      filt_cnt_ff <= nxt_filt_cnt;
    end
  end

  cs_filter_a: assert property ($rose(cs_act_ff) |->
    $past(cs_s2_ff, 1) == 1'b0 && $past(filt_cnt_ff, 1) == 8'hf9)
    else $error("select accepted before setup time");

  // ==========================================================
  // Transfer and conversion sequencer
  sac_pkg::sac_state_t state_ff, nxt_state;
  logic [4:0] bit_cnt_ff, nxt_bit_cnt, nclk;
  logic [3:0] rise_cnt_ff, nxt_rise_cnt;
  logic [7:0] cmd_sr_ff, nxt_cmd_sr, cmd_ff, nxt_cmd;
  logic [15:0] out_sr_ff, nxt_out_sr, res_ff, nxt_res;
  logic [11:0] conv_cnt_ff, nxt_conv_cnt, raw_code;
  logic eoc_ff, nxt_eoc, dout_ff, nxt_dout, oe_n_ff, nxt_oe_n;
  logic sample_ff, nxt_sample;
  logic [3:0] mux_ff, nxt_mux;
  logic xfer_ok, last_fall;
  logic buf_in_valid, buf_in_ready, buf_out_valid, buf_out_ready;
  logic [15:0] buf_in_data, buf_out_data;

  // Left-aligned word; bipolar flips the MSB, LSB-first reverses
  function automatic logic [15:0] fmt(input logic [11:0] c,
                                      input logic lsbf,
                                      input logic bip);
    logic [11:0] v;
    logic [11:0] r;
    v = c;
    r = 12'h000;
    if (bip)
      v[11] = ~v[11];
    for (int i = 0; i < 12; i++)
      r[i] = v[11-i];
    fmt = {(lsbf ? r : v), 4'h0};
  endfunction

  always_comb
  begin
    case (cmd_sr_ff[sac_pkg::LEN_POS +: 2])
      sac_pkg::LEN_8: nclk = sac_pkg::NCLK_8;
      sac_pkg::LEN_16: nclk = sac_pkg::NCLK_16;
      default: nclk = sac_pkg::NCLK_12;
    endcase
  end

  always_comb
  begin
    // Self-test codes bypass the analog result entirely
    case (cmd_ff[sac_pkg::ADDR_POS +: 4])
      sac_pkg::ST_MID: raw_code = sac_pkg::CODE_MID;
      sac_pkg::ST_ZERO: raw_code = sac_pkg::CODE_ZERO;
      sac_pkg::ST_FULL: raw_code = sac_pkg::CODE_FULL;
      default:
        if (ana_over)
          raw_code = sac_pkg::CODE_FULL;
        else if (ana_under)
          raw_code = sac_pkg::CODE_ZERO;
        else
          raw_code = ana_code;
    endcase
  end

  assign xfer_ok = cs_act_ff && (state_ff == sac_pkg::SAC_IDLE) && eoc_ff;
  assign last_fall = xfer_ok && io_fall && (bit_cnt_ff == nclk - 5'h01);
  assign buf_in_valid = (state_ff == sac_pkg::SAC_PUSH);
  assign buf_in_data = fmt(raw_code, cmd_ff[sac_pkg::LSBF_POS],
                           cmd_ff[sac_pkg::BIP_POS]);
  assign buf_out_ready = (state_ff == sac_pkg::SAC_IDLE) && !eoc_ff;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_rise_cnt = rise_cnt_ff;
    nxt_cmd_sr = cmd_sr_ff;
    nxt_cmd = cmd_ff;
    nxt_out_sr = out_sr_ff;
    nxt_res = res_ff;
    nxt_conv_cnt = conv_cnt_ff;
    nxt_eoc = eoc_ff;
    nxt_sample = sample_ff;
    nxt_mux = mux_ff;
    nxt_dout = out_sr_ff[15];
    // Release follows the synchronised pin so it is not slowed by the filter
    nxt_oe_n = cs_s2_ff | ~cs_act_ff;
    case (state_ff)
      sac_pkg::SAC_IDLE:
        if (buf_out_valid && !eoc_ff)
        begin
          nxt_res = buf_out_data;
          nxt_out_sr = buf_out_data;
          nxt_eoc = 1'b1;
        end
        else if (cs_sel_p || cs_desel_p)
        begin
          // Each framed transfer restarts with the held result
          nxt_out_sr = res_ff;
          nxt_bit_cnt = 5'h00;
          nxt_rise_cnt = 4'h0;
          nxt_sample = 1'b0;
        end
        else if (xfer_ok)
        begin
          if (io_rise && rise_cnt_ff < sac_pkg::CMD_BITS)
          begin
            nxt_cmd_sr = {cmd_sr_ff[6:0], din_s2_ff};
            nxt_rise_cnt = rise_cnt_ff + 4'h1;
          end
          if (io_fall)
          begin
            nxt_out_sr = {out_sr_ff[14:0], 1'b0};
            nxt_bit_cnt = bit_cnt_ff + 5'h01;
            if (bit_cnt_ff == sac_pkg::ACQ_START - 5'h01)
            begin
              nxt_sample = 1'b1;
              // Only the four address bits have arrived by this fall
              nxt_mux = cmd_sr_ff[3:0];
            end
            if (last_fall)
            begin
              nxt_state = sac_pkg::SAC_CONV;
              nxt_cmd = cmd_sr_ff;
              nxt_eoc = 1'b0;
              nxt_sample = 1'b0;
              nxt_bit_cnt = 5'h00;
              nxt_rise_cnt = 4'h0;
              nxt_conv_cnt = 12'h000;
            end
          end
        end
      sac_pkg::SAC_CONV:
        if (cs_sel_p)
        begin
          // Abort keeps the previous result for the next frame
          nxt_state = sac_pkg::SAC_IDLE;
          nxt_eoc = 1'b1;
          nxt_out_sr = res_ff;
        end
        else if (conv_cnt_ff == 12'(sac_pkg::CONV_CYC - 1))
          nxt_state = sac_pkg::SAC_PUSH;
        else
          nxt_conv_cnt = conv_cnt_ff + 12'h001;
      sac_pkg::SAC_PUSH:
        if (buf_in_ready)
          nxt_state = sac_pkg::SAC_IDLE;
      default:
        nxt_state = sac_pkg::SAC_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff <= sac_pkg::SAC_IDLE;
      bit_cnt_ff <= 5'h00;
      rise_cnt_ff <= 4'h0;
      cmd_sr_ff <= sac_pkg::CMD_RST;
      cmd_ff <= sac_pkg::CMD_RST;
      out_sr_ff <= sac_pkg::RES_RST;
      res_ff <= sac_pkg::RES_RST;
      conv_cnt_ff <= 12'h000;
      eoc_ff <= 1'b1;
      dout_ff <= 1'b0;
      oe_n_ff <= 1'b1;
      sample_ff <= 1'b0;
      mux_ff <= 4'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      bit_cnt_ff <= nxt_bit_cnt;
      rise_cnt_ff <= nxt_rise_cnt;
      cmd_sr_ff <= nxt_cmd_sr;
      cmd_ff <= nxt_cmd;
      out_sr_ff <= nxt_out_sr;
      res_ff <= nxt_res;
      conv_cnt_ff <= nxt_conv_cnt;
      eoc_ff <= nxt_eoc;
      dout_ff <= nxt_dout;
      oe_n_ff <= nxt_oe_n;
      sample_ff <= nxt_sample;
      mux_ff <= nxt_mux;
    end
  end

  sac_buf2 #(.W(16)) u_buf (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(buf_in_data),
    .out_valid(buf_out_valid),
    .out_ready(buf_out_ready),
    .out_data(buf_out_data)
  );

  assign eoc = eoc_ff;
  assign dout = dout_ff;
  assign dout_oe_n = oe_n_ff;
  assign mux_sel = mux_ff;
  assign sample = sample_ff;

  // ==========================================================
  // Checks
  // Busy time is counted, as its bound is too long for a delay range
  logic [11:0] busy_age_ff, nxt_busy_age;

  always_comb
  begin
    nxt_busy_age = 12'h000;
    if (!eoc_ff && busy_age_ff != 12'hfff)
      nxt_busy_age = busy_age_ff + 12'h001;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      busy_age_ff <= 12'h000;
    else
      busy_age_ff <= nxt_busy_age;
  end

  self_test_a: assert property (buf_in_valid &&
    cmd_ff[7:4] == 4'hd |-> raw_code == 12'hfff)
    else $error("self-test full code wrong");
  clamp_code_a: assert property (buf_in_valid && ana_over &&
    cmd_ff[7:4] < 4'hb |-> raw_code == 12'hfff)
    else $error("over-range not clamped");
  eoc_fall_a: assert property (last_fall |->
    ##[1:EOC_W] !eoc_ff)
    else $error("conversion-done did not fall");
  conv_time_a: assert property (!eoc_ff |->
    busy_age_ff < 12'(CONV_W))
    else $error("conversion too long");
  first_bit_a: assert property ($rose(eoc_ff) |->
    ##[1:DOUT_W] dout_ff == res_ff[15])
    else $error("first result bit late");
  oe_off_a: assert property (cs_s2_ff |->
    ##[1:OFF_W] oe_n_ff)
    else $error("output not released");
  oe_on_a: assert property ($rose(cs_act_ff) ##1 !cs_s2_ff |->
    !oe_n_ff)
    else $error("output not driven after select");
  abort_conv_a: assert property (state_ff == sac_pkg::SAC_CONV &&
    cs_sel_p |=> state_ff == sac_pkg::SAC_IDLE && eoc_ff)
    else $error("abort not taken");
  acq_window_a: assert property (sample_ff |->
    state_ff == sac_pkg::SAC_IDLE && bit_cnt_ff >= 5'h04)
    else $error("sampling outside window");
  eoc_ready_a: assert property (buf_out_valid && buf_out_ready |=>
    eoc_ff && res_ff == $past(buf_out_data))
    else $error("ready result not flagged");
  len_end_a: assert property (last_fall &&
    cmd_sr_ff[3:2] == 2'h1 |-> rise_cnt_ff == 4'h8)
    else $error("8-clock transfer ended before its command");
endmodule
`default_nettype wire

// ### verification/sac_host.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Host serial port model
module sac_host (
  input wire logic core_clk,
  input wire logic dout,
  input wire logic eoc,
  output logic cs_n_pin,
  output logic io_clk_pin,
  output logic din_pin
);
  localparam int HALF = 20;
  localparam int SETUP = 400;
  initial
  begin
    cs_n_pin = 1'b1;
    io_clk_pin = 1'b0;
    din_pin = 1'b0;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic sel(input logic v);
    cs_n_pin = v;
  endtask
  // Clock stands low between frames; din toggles once unused
  task automatic xfer(input logic [7:0] cmd, input int n,
    input bit framed, output logic [15:0] rx);
    int w;
    rx = 16'h0000;
    w = 0;
    while (eoc !== 1'b1 && w < 4000)
    begin
      w++;
      cyc(1);
    end
    if (cs_n_pin)
    begin
      cs_n_pin = 1'b0;
      cyc(SETUP);
    end
    for (int i = 0; i < n; i++)
    begin
      din_pin = (i < 8) ? cmd[7-i] : ~din_pin;
      cyc(HALF);
      io_clk_pin = 1'b1;
      rx = {rx[14:0], dout};
      cyc(HALF);
      io_clk_pin = 1'b0;
    end
    din_pin = ~din_pin;
    cyc(2);
    if (framed)
      cs_n_pin = 1'b1;
  endtask
endmodule
`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define SAC_CHK(a, e, m) \
  begin \
    total_checks++; \
    if ((a) !== (e)) \
    begin \
      mismatches++; \
      $display("MISMATCH %0t %s", $time, m); \
    end \
  end
module tb_top;
  logic core_clk, rst, cs_n_pin, io_clk_pin, din_pin;
  logic ana_over, ana_under, eoc, dout, dout_oe_n, sample, dout_line;
  logic [11:0] ana_code;
  logic [3:0] mux_sel;
  logic [15:0] pend;
  int mismatches, total_checks, samp_cnt;
  bit oe_fell;
  // Undriven line shows the inverse so a stale read is caught
  assign dout_line = dout_oe_n ? ~dout : dout;
  sac_ctrl i_sac_ctrl (.core_clk(core_clk), .rst(rst),
    .cs_n_pin(cs_n_pin), .io_clk_pin(io_clk_pin), .din_pin(din_pin),
    .ana_code(ana_code), .ana_over(ana_over), .ana_under(ana_under),
    .eoc(eoc), .dout(dout), .dout_oe_n(dout_oe_n), .mux_sel(mux_sel),
    .sample(sample));
  sac_host i_sac_host (.core_clk(core_clk), .dout(dout_line),
    .eoc(eoc), .cs_n_pin(cs_n_pin), .io_clk_pin(io_clk_pin),
    .din_pin(din_pin));
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
    if (sample === 1'b1)
      samp_cnt++;
  always @(negedge dout_oe_n)
    oe_fell = 1'b1;
  // ==========================================================
  // Helpers
  function automatic logic [15:0] fmt(logic [11:0] c, logic l, logic b);
    logic [11:0] r;
    c[11] = c[11] ^ b;
    for (int i = 0; i < 12; i++)
      r[i] = c[11-i];
    return {l ? r : c, 4'h0};
  endfunction
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // One transfer, then busy and completion timing
  task automatic xf(input logic [7:0] cmd, input bit framed,
    input logic [11:0] code, input logic ov, input logic un,
    input bit chk, input bit ab);
    logic [15:0] rx;
    logic [11:0] res;
    int n;
    int w;
    n = (cmd[3:2] == sac_pkg::LEN_8) ? 8 :
      (cmd[3:2] == sac_pkg::LEN_16) ? 16 : 12;
    ana_code = code;
    ana_over = ov;
    ana_under = un;
    samp_cnt = 0;
    i_sac_host.xfer(cmd, n, framed, rx);
    if (chk)
      `SAC_CHK(rx, pend >> (16 - n), "result word")
    `SAC_CHK(mux_sel, cmd[7:4], "channel select")
    `SAC_CHK((samp_cnt + 20) / 40, n - 4, "acquisition span")
    w = 0;
    while (eoc !== 1'b0 && w < sac_pkg::EOC_FALL_CYC)
    begin
      w++;
      i_sac_host.cyc(1);
    end
    `SAC_CHK(eoc, 1'b0, "busy flag late")
    if (ab)
    begin
      i_sac_host.cyc(300);
      i_sac_host.sel(1'b0);
      i_sac_host.cyc(300);
      `SAC_CHK(eoc, 1'b1, "abort ignored")
      return;
    end
    res = (cmd[7:4] == sac_pkg::ST_MID) ? sac_pkg::CODE_MID :
      (cmd[7:4] == sac_pkg::ST_ZERO) ? sac_pkg::CODE_ZERO :
      (cmd[7:4] == sac_pkg::ST_FULL) ? sac_pkg::CODE_FULL :
      ov ? sac_pkg::CODE_FULL : un ? sac_pkg::CODE_ZERO : code;
    pend = fmt(res, cmd[1], cmd[0]);
    w = 0;
    while (eoc !== 1'b1 && w < sac_pkg::CONV_MAX_CYC)
    begin
      w++;
      i_sac_host.cyc(1);
    end
    `SAC_CHK(eoc, 1'b1, "conversion late")
    if (!framed)
    begin
      i_sac_host.cyc(sac_pkg::DOUT_EOC_CYC);
      `SAC_CHK(dout, pend[15], "first bit late")
    end
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    `SAC_CHK({eoc, dout_oe_n, sample, mux_sel}, 7'h60, "reset")
  endtask
  task automatic t_glitch;
    oe_fell = 1'b0;
    i_sac_host.sel(1'b0);
    i_sac_host.cyc(100);
    i_sac_host.sel(1'b1);
    i_sac_host.cyc(300);
    `SAC_CHK(oe_fell, 1'b0, "glitch accepted")
  endtask
  task automatic t_oe;
    i_sac_host.sel(1'b0);
    i_sac_host.cyc(sac_pkg::OE_ON_CYC);
    `SAC_CHK(dout_oe_n, 1'b0, "output not driven")
    i_sac_host.sel(1'b1);
    i_sac_host.cyc(sac_pkg::OE_OFF_CYC);
    `SAC_CHK(dout_oe_n, 1'b1, "output not released")
    i_sac_host.cyc(300);
  endtask
  task automatic t_selftest;
    xf({sac_pkg::ST_MID, 4'h0}, 1'b1, 12'h5a3, 1'b0, 1'b0, 1'b1, 1'b0);
    xf({sac_pkg::ST_ZERO, 4'h0}, 1'b1, 12'h5a3, 1'b0, 1'b0, 1'b1, 1'b0);
    xf({sac_pkg::ST_FULL, 4'h0}, 1'b1, 12'h5a3, 1'b0, 1'b0, 1'b1, 1'b0);
  endtask
  task automatic t_clamp;
    xf({4'h3, sac_pkg::LEN_8, 2'h0}, 1'b1, 12'h5a3, 1'b1, 1'b0, 1'b1, 1'b0);
    xf({4'h5, sac_pkg::LEN_16, 2'h0}, 1'b1, 12'h5a3, 1'b0, 1'b1, 1'b1, 1'b0);
  endtask
  // Continuous frames, then a framed one that releases the select
  task automatic t_cont;
    xf({4'h6, 2'h0, 2'h3}, 1'b0, 12'ha5c, 1'b0, 1'b0, 1'b1, 1'b0);
    xf({4'h7, 2'h0, 2'h3}, 1'b0, 12'h123, 1'b0, 1'b0, 1'b1, 1'b0);
    xf({4'h8, 4'h0}, 1'b1, 12'h321, 1'b0, 1'b0, 1'b1, 1'b0);
  endtask
  task automatic t_abort;
    xf({4'h9, 4'h0}, 1'b1, 12'h777, 1'b0, 1'b0, 1'b1, 1'b1);
    xf({4'ha, 4'h0}, 1'b1, 12'h000, 1'b0, 1'b0, 1'b1, 1'b0);
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial
  begin
    rst = 1'b1;
    ana_code = 12'h000;
    ana_over = 1'b0;
    ana_under = 1'b0;
    pend = sac_pkg::RES_RST;
    mismatches = 0;
    total_checks = 0;
    samp_cnt = 0;
    oe_fell = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    rst = 1'b0;
    t_reset;
    t_glitch;
    t_oe;
    t_selftest;
    t_clamp;
    t_cont;
    t_abort;
    tally_and_finish;
  end
  initial
  begin
    repeat (80000) @(posedge core_clk);
    mismatches++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
